/* verilog/charger_defs.vh */
`ifndef CHARGER_DEFS_VH
`define CHARGER_DEFS_VH
`define SLAVE_ADDR      7'h09
`define CMD_SPEC        8'h11
`define CMD_MODE        8'h12
`define CMD_STATUS      8'h13
`define CMD_CURRENT     8'h14
`define CMD_VOLTAGE     8'h15
`define CMD_ALARM       8'h16
`define CMD_INPUT       8'h3f
`define CMD_MAKER       8'hfe
`define CMD_PART        8'hff
`define SPEC_WORD       16'h0002
`define CUR_RESET       16'h0080
`define VOLT_RESET      16'h4b00
`define INP_RESET       16'h0080
`define CUR_MASK        16'h1f80
`define CUR_MIN         16'h0080
`define CUR_MAX         16'h1f80
`define VOLT_MASK       16'h7ff0
`define VOLT_MIN        16'h0400
`define VOLT_MAX        16'h4b00
`define INP_MASK        16'h1f80
`define INP_MAX         16'h2afc
`define ALARM_MASK      16'hf800
`define MODE_INHIBIT    0
`define MODE_RESTORE    2
`define MODE_HALT_EN    10
`define ST_CHG_OFF      0
`define ST_HALT_EN      4
`define ST_CUR_OR       6
`define ST_VOLT_OR      7
`define ST_UNDERRANGE   9
`define ST_OVERTEMP     10
`define ST_ALARM        11
`define ST_LOW_INPUT    13
`define ST_PACK         14
`define ST_ADAPTER      15
`endif

/* verilog/smart_charger_bus_command_unit.v */
`timescale 1ns/1ps
`include "charger_defs.vh"
module smart_charger_bus_command_unit #(
    parameter [15:0] MAKER_CODE = 16'h1234, // Arbitrary value.
    parameter [15:0] PART_CODE  = 16'h0001  // Arbitrary value.
) (
    // Clock and reset.
    input  wire        i_ref_clk,
    input  wire        i_rst_b,
    // Bus pins.
    input  wire        i_scl,
    input  wire        i_sda,
    output reg         o_sda_out,
    output reg         o_sda_oe,
    // Comparator inputs.
    input  wire        i_adapter_input_ok,
    input  wire        i_low_input,
    input  wire        i_thermistor_sense_low,
    input  wire        i_overtemp_latch,
    input  wire        i_thermistor_underrange,
    input  wire        i_battery_sense_low,
    input  wire        i_battery_sense_recovered,
    input  wire        i_supply_low,
    // Control outputs.
    output reg         o_source_switch_drive,
    output reg         o_regulator_on,
    output reg  [15:0] o_current_setting,
    output reg  [15:0] o_voltage_setting,
    output reg  [15:0] o_input_limit
);

// ****************************************************************
// Input synchronisers
// ****************************************************************

reg [9:0] s1_q;
reg [9:0] s2_q;
reg       scl_d1_q;
reg       sda_d1_q;

// All pins pass two flops; only the second stage feeds logic.
// The bus lines reset high so that reset release does not look like
// a start; comparator bits reset low and are re-read within two clocks.
always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        s1_q     <= 10'h3;
        s2_q     <= 10'h3;
        scl_d1_q <= 1'b1;
        sda_d1_q <= 1'b1;
    end else begin
        s1_q     <= {i_supply_low, i_battery_sense_recovered,
                     i_battery_sense_low, i_thermistor_underrange,
                     i_overtemp_latch, i_thermistor_sense_low,
                     i_low_input, i_adapter_input_ok, i_sda, i_scl};
        s2_q     <= s1_q;
        scl_d1_q <= s2_q[0];
        sda_d1_q <= s2_q[1];
    end
end

wire scl       = s2_q[0];
wire sda       = s2_q[1];
wire adapter   = s2_q[2];
wire low_in    = s2_q[3];
wire pack      = s2_q[4];
wire hot       = s2_q[5];
wire underr    = s2_q[6];
wire battery_sense_low  = s2_q[7];
wire battery_sense_ok   = s2_q[8];
wire supply_lo = s2_q[9];
wire scl_rise  = scl & ~scl_d1_q;
wire scl_fall  = ~scl & scl_d1_q;
wire start_ev  = scl & scl_d1_q & ~sda & sda_d1_q;
wire stop_ev   = scl & scl_d1_q & sda & ~sda_d1_q;

// ****************************************************************
// Bus slave state machine
// ****************************************************************

localparam [4:0] S_IDLE = 5'b00001;
localparam [4:0] S_RX   = 5'b00010;
localparam [4:0] S_ACK  = 5'b00100;
localparam [4:0] S_TX   = 5'b01000;
localparam [4:0] S_MACK = 5'b10000;

reg [4:0]  state_q;
reg [3:0]  bit_q;
reg [7:0]  sh_q;
reg [2:0]  byte_q;
reg        rd_q;
reg [7:0]  cmd_q;
reg [7:0]  lo_q;
reg [15:0] tx_q;
reg        wr_go_q;
reg [15:0] wr_data_q;

// Read data for a command; unknown codes read as zero.
function [15:0] read_word;
    input [7:0]  c;
    input [15:0] st;
    begin
        if (c == `CMD_SPEC)
            read_word = `SPEC_WORD;
        else if (c == `CMD_STATUS)
            read_word = st;
        else if (c == `CMD_MAKER)
            read_word = MAKER_CODE;
        else if (c == `CMD_PART)
            read_word = PART_CODE;
        else
            read_word = 16'h0000;
    end
endfunction

wire [15:0] status_w;

// Word for the addressed command, latched when the read begins.
wire [15:0] rd_word = read_word(cmd_q, status_w);

// Bytes are shifted in MSB first on SCL rises; SDA changes on falls.
always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        state_q   <= S_IDLE;
        bit_q     <= 4'h0;
        sh_q      <= 8'h00;
        byte_q    <= 3'h0;
        rd_q      <= 1'b0;
        cmd_q     <= 8'h00;
        lo_q      <= 8'h00;
        tx_q      <= 16'h0000;
        wr_go_q   <= 1'b0;
        wr_data_q <= 16'h0000;
        o_sda_out <= 1'b0;
        o_sda_oe  <= 1'b0;
    end else begin
        wr_go_q <= 1'b0;
        if (supply_lo) begin
            state_q  <= S_IDLE;
            o_sda_oe <= 1'b0;
        end else if (stop_ev) begin
            state_q  <= S_IDLE;
            o_sda_oe <= 1'b0;
            // Commit only a full four-byte write.
            if (!rd_q && byte_q == 3'h4) begin
                wr_go_q   <= 1'b1;
                wr_data_q <= {sh_q, lo_q};
            end
        end else if (start_ev) begin
            state_q  <= S_RX;
            bit_q    <= 4'h0;
            byte_q   <= 3'h0;
            o_sda_oe <= 1'b0;
        end else begin
            case (state_q)
                S_RX: begin
                    if (scl_rise) begin
                        sh_q  <= {sh_q[6:0], sda};
                        bit_q <= bit_q + 4'h1;
                    end else if (scl_fall && bit_q == 4'h8) begin
                        bit_q <= 4'h0;
                        if (byte_q == 3'h0 &&
                            sh_q[7:1] != `SLAVE_ADDR) begin
                            state_q <= S_IDLE;
                        end else begin
                            state_q   <= S_ACK;
                            o_sda_oe  <= 1'b1;
                            o_sda_out <= 1'b0;
                            if (byte_q == 3'h0)
                                rd_q <= sh_q[0];
                            if (byte_q == 3'h1)
                                cmd_q <= sh_q;
                            if (byte_q == 3'h2)
                                lo_q <= sh_q;
                            byte_q <= byte_q + 3'h1;
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        if (rd_q && byte_q == 3'h1) begin
                            // Read: low byte first.
                            tx_q      <= rd_word;
                            state_q   <= S_TX;
                            o_sda_out <= rd_word[7];
                            o_sda_oe  <= ~rd_word[7];
                        end else if (byte_q < 3'h4) begin
                            state_q  <= S_RX;
                            o_sda_oe <= 1'b0;
                        end else begin
                            state_q  <= S_IDLE;
                            o_sda_oe <= 1'b0;
                        end
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h7) begin
                            state_q  <= S_MACK;
                            o_sda_oe <= 1'b0;
                        end else begin
                            // Open drain: a one is sent by releasing SDA.
                            o_sda_out <= tx_q[6 - bit_q[2:0]];
                            o_sda_oe  <= ~tx_q[6 - bit_q[2:0]];
                        end
                    end
                end
                S_MACK: begin
                    if (scl_rise) begin
                        bit_q <= 4'h0;
                        if (sda || byte_q == 3'h2) begin
                            state_q <= S_IDLE;
                        end else begin
                            tx_q    <= {8'h00, tx_q[15:8]};
                            byte_q  <= 3'h2;
                        end
                    end else if (scl_fall) begin
                        // Only an acked low byte gets here: the high
                        // byte's first bit goes out as the ack clock ends,
                        // so the master sees it before its next rise.
                        state_q   <= S_TX;
                        o_sda_out <= tx_q[7];
                        o_sda_oe  <= ~tx_q[7];
                    end
                end
                default: begin
                    o_sda_oe <= 1'b0;
                end
            endcase
        end
    end
end

// ****************************************************************
// Command registers and charger state
// ****************************************************************

reg [15:0] cur_q;
reg [15:0] volt_q;
reg [15:0] inp_q;
reg        halt_en_q;
reg        chg_off_q;
reg        hot_q;
reg        alarm_q;
reg        cur_or_q;
reg        volt_or_q;
reg        uv_q;

// Write strobes, one clock wide, decoded from the committed command.
wire [15:0] cur_m  = wr_data_q & `CUR_MASK;
wire [15:0] volt_m = wr_data_q & `VOLT_MASK;
wire [15:0] inp_m  = wr_data_q & `INP_MASK;
wire        is_cur = wr_go_q && cmd_q == `CMD_CURRENT;
wire        is_vlt = wr_go_q && cmd_q == `CMD_VOLTAGE;
wire        is_mod = wr_go_q && cmd_q == `CMD_MODE;
wire        restore = is_mod && wr_data_q[`MODE_RESTORE];

// Supply undervoltage returns state to power-on; battery removal restores the targets, halt enable and the hot and alarm latches.
always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        cur_q     <= `CUR_RESET;
        volt_q    <= `VOLT_RESET;
        inp_q     <= `INP_RESET;
        halt_en_q <= 1'b1;
        chg_off_q <= 1'b0;
        hot_q     <= 1'b0;
        alarm_q   <= 1'b0;
        cur_or_q  <= 1'b0;
        volt_or_q <= 1'b0;
        uv_q      <= 1'b0;
    end else if (supply_lo) begin
        cur_q     <= `CUR_RESET;
        volt_q    <= `VOLT_RESET;
        inp_q     <= `INP_RESET;
        halt_en_q <= 1'b1;
        chg_off_q <= 1'b0;
        hot_q     <= 1'b0;
        alarm_q   <= 1'b0;
        cur_or_q  <= 1'b0;
        volt_or_q <= 1'b0;
        uv_q      <= 1'b0;
    end else begin
        // Battery undervoltage with recovery hysteresis.
        if (battery_sense_low)
            uv_q <= 1'b1;
        else if (battery_sense_ok)
            uv_q <= 1'b0;
        if (is_cur) begin
            alarm_q <= 1'b0;
            if (wr_data_q > `CUR_MAX) begin
                cur_q    <= `CUR_MAX;
                cur_or_q <= 1'b1;
            end else begin
                cur_or_q <= 1'b0;
                if (wr_data_q != 16'h0000 && cur_m < `CUR_MIN)
                    cur_q <= `CUR_MIN;
                else
                    cur_q <= cur_m;
            end
        end
        if (is_vlt) begin
            alarm_q <= 1'b0;
            volt_or_q <= (wr_data_q > `VOLT_MAX);
            if (wr_data_q > `VOLT_MAX)
                volt_q <= `VOLT_MAX;
            else if (wr_data_q < `VOLT_MIN)
                volt_q <= 16'h0000;
            else
                volt_q <= volt_m;
        end
        if (wr_go_q && cmd_q == `CMD_INPUT)
            inp_q <= (wr_data_q > `INP_MAX) ? `INP_MAX : inp_m;
        if (wr_go_q && cmd_q == `CMD_ALARM &&
            (wr_data_q & `ALARM_MASK) != 16'h0000)
            alarm_q <= 1'b1;
        if (is_mod) begin
            chg_off_q <= wr_data_q[`MODE_INHIBIT];
            halt_en_q <= wr_data_q[`MODE_HALT_EN];
        end
        if (restore) begin
            cur_q     <= `CUR_RESET;
            volt_q    <= `VOLT_RESET;
            hot_q     <= 1'b0;
            alarm_q   <= 1'b0;
        end
        // Hot thermistor latches while a pack is present; a hot reading
        // in the same cycle as a restore write wins, so none is lost.
        if (hot && pack)
            hot_q <= 1'b1;
        // Removal wins over everything else.
        if (!pack) begin
            cur_q     <= `CUR_RESET;
            volt_q    <= `VOLT_RESET;
            halt_en_q <= 1'b1;
            hot_q     <= 1'b0;
            alarm_q   <= 1'b0;
        end
        // Other codes, including read-only ones, fall through.
    end
end

// Status word; comparator bits are live, the others are latches.
assign status_w = {adapter, pack, low_in, 1'b0, alarm_q, hot_q,
                   underr, 1'b0, volt_or_q, cur_or_q, 1'b0,
                   halt_en_q, 3'b000, chg_off_q};

// ****************************************************************
// Control outputs
// ****************************************************************

// Any one of these holds the regulator off; the hot latch only counts
// while its halt enable is set, so a host can charge a warm pack.
wire chg_ok = adapter && !low_in && !supply_lo && !alarm_q &&
              !chg_off_q && !(hot_q && halt_en_q) &&
              volt_q != 16'h0000;

// Settings are registered so the analog side sees clean levels.
always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_source_switch_drive <= 1'b0;
        o_regulator_on        <= 1'b0;
        o_current_setting     <= `CUR_RESET;
        o_voltage_setting     <= `VOLT_RESET;
        o_input_limit         <= `INP_RESET;
    end else begin
        o_source_switch_drive <= adapter && !low_in;
        o_regulator_on        <= chg_ok;
        o_current_setting     <= (uv_q && cur_q > `CUR_MIN) ?
                                 `CUR_MIN : cur_q;
        o_voltage_setting     <= volt_q;
        o_input_limit         <= inp_q;
    end
end

endmodule

/* dv/charger_bus_monitor.sv */
`timescale 1ns/1ps
module charger_bus_monitor (
    // Clock and reset.
    input wire        i_ref_clk,
    input wire        i_rst_b,
    // Bus and comparator pins.
    input wire        i_scl,
    input wire        o_sda_out,
    input wire        o_sda_oe,
    input wire        i_adapter_input_ok,
    input wire        i_low_input,
    input wire        i_thermistor_sense_low,
    input wire        i_battery_sense_low,
    input wire        i_supply_low,
    // Control outputs.
    input wire        o_source_switch_drive,
    input wire        o_regulator_on,
    input wire [15:0] o_current_setting,
    input wire [15:0] o_voltage_setting,
    input wire [15:0] o_input_limit
);
    // ************************************************************
    // Checks on the pins.
    // ************************************************************
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // Levels must outlast the synchronisers before effects are due.
    sequence s_supply_low;
        i_supply_low [*8];
    endsequence
    sequence s_pack_gone;
        (!i_thermistor_sense_low && !i_supply_low) [*8];
    endsequence
    a_sda_pull_low:
        assert property (o_sda_oe |-> !o_sda_out)
        else $error("SDA driven high");
    a_sda_scl_low:
        assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("SDA changed while SCL high");
    a_supply_reset:
        assert property (s_supply_low |-> !o_regulator_on && !o_sda_oe
            && o_voltage_setting == 16'h4b00
            && o_input_limit == 16'h0080)
        else $error("state kept in supply undervoltage");
    a_power_fail:
        assert property (i_low_input [*8] |-> !o_source_switch_drive)
        else $error("source switch on in power fail");
    a_adapter_gone:
        assert property ((!i_adapter_input_ok) [*8] |-> !o_regulator_on)
        else $error("charging without adapter");
    a_undervolt_cap:
        assert property ((i_battery_sense_low && !i_supply_low) [*8]
            |-> o_current_setting <= 16'h0080)
        else $error("current not capped");
    a_pack_removed:
        assert property (s_pack_gone |-> o_current_setting == 16'h0080
            && o_voltage_setting == 16'h4b00)
        else $error("targets not restored");
    a_cur_bounds:
        assert property (o_current_setting <= 16'h1f80
            && (o_current_setting & 16'he07f) == 16'h0000)
        else $error("current setting out of range");
    a_volt_bounds:
        assert property (o_voltage_setting == 16'h0000
            || (o_voltage_setting >= 16'h0400
            && o_voltage_setting <= 16'h4b00
            && o_voltage_setting[3:0] == 4'h0))
        else $error("voltage setting out of range");
    a_input_bound:
        assert property (o_input_limit <= 16'h2afc)
        else $error("input limit above maximum");
endmodule
bind smart_charger_bus_command_unit charger_bus_monitor u_mon (.*);

/* dv/smbus_host_model.sv */
`timescale 1ns/1ps
`include "charger_defs.vh"
module smbus_host_model (
    // Clock and bus.
    input  wire i_clk,
    input  wire i_sda,
    output reg  o_scl,
    output reg  o_sda
);
    // ************************************************************
    // Bus master.
    // ************************************************************
    // Both lines idle released; the clock stands still between frames.
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task w(input integer n);
        repeat (n) @(negedge i_clk);
    endtask
    // Low 56 ns so a slow acknowledge lands; sampled late in high.
    task pulse(input b, output s);
        begin
            w(1);
            o_sda = b;
            w(6);
            o_scl = 1'b1;
            w(3);
            s = i_sda;
            o_scl = 1'b0;
        end
    endtask
    task start;
        begin
            w(1);
            o_sda = 1'b1;
            w(6);
            o_scl = 1'b1;
            w(3);
            o_sda = 1'b0;
            w(3);
            o_scl = 1'b0;
        end
    endtask
    task stop;
        begin
            w(1);
            o_sda = 1'b0;
            w(6);
            o_scl = 1'b1;
            w(3);
            o_sda = 1'b1;
            w(8);
        end
    endtask
    task xfer(input [7:0] d, input a, output [7:0] q, output k);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                pulse(d[i], q[i]);
            end
            pulse(a, k);
        end
    endtask
    // Address, command, low byte, high byte; any NACK is reported.
    task wr(input [6:0] a, input [7:0] c, input [15:0] d, output n);
        reg [7:0] q;
        reg       k0;
        reg       k1;
        reg       k2;
        reg       k3;
        begin
            start;
            xfer({a, 1'b0}, 1'b1, q, k0);
            xfer(c, 1'b1, q, k1);
            xfer(d[7:0], 1'b1, q, k2);
            xfer(d[15:8], 1'b1, q, k3);
            stop;
            n = k0 | k1 | k2 | k3;
        end
    endtask
    task rd(input [7:0] c, output [15:0] d, output n);
        reg [7:0] q;
        reg       k0;
        reg       k1;
        reg       k2;
        reg       kx;
        begin
            start;
            xfer({`SLAVE_ADDR, 1'b0}, 1'b1, q, k0);
            xfer(c, 1'b1, q, k1);
            start;
            xfer({`SLAVE_ADDR, 1'b1}, 1'b1, q, k2);
            xfer(8'hff, 1'b0, d[7:0], kx);
            xfer(8'hff, 1'b1, d[15:8], kx);
            stop;
            n = k0 | k1 | k2;
        end
    endtask
endmodule

/* dv/smart_charger_bus_command_unit_test.sv */
`timescale 1ns/1ps
`include "charger_defs.vh"
module smart_charger_bus_command_unit_test;
    localparam [15:0] MAKER = 16'h5a5a; // Arbitrary value.
    localparam [15:0] PART  = 16'h00c3; // Arbitrary value.
    reg         clk = 1'b0;
    reg         rst_b = 1'b0;
    reg         ad = 1'b1;
    reg         lin = 1'b0;
    reg         pk = 1'b1;
    reg         bl = 1'b0;
    reg         br = 1'b1;
    reg         sl = 1'b0;
    reg         hot = 1'b0;
    reg         ur = 1'b0;
    reg  [15:0] q;
    reg         n;
    integer     error_cnt = 0;
    integer     num_checks = 0;
    wire        scl;
    wire        m_sda;
    wire        sda;
    wire        sda_out;
    wire        sda_oe;
    wire        sw;
    wire        reg_on;
    wire [15:0] cur;
    wire [15:0] volt;
    wire [15:0] inp;
    // Open-drain bus with pull-up: any party may pull it low.
    assign sda = m_sda & (sda_oe ? sda_out : 1'b1);
    // Free-running 125 MHz clock.
    always #4 clk = ~clk;
    smart_charger_bus_command_unit #(
        .MAKER_CODE (MAKER),
        .PART_CODE  (PART)
    ) DUT (
        .i_ref_clk                 (clk),
        .i_rst_b                   (rst_b),
        .i_scl                     (scl),
        .i_sda                     (sda),
        .o_sda_out                 (sda_out),
        .o_sda_oe                  (sda_oe),
        .i_adapter_input_ok        (ad),
        .i_low_input               (lin),
        .i_thermistor_sense_low    (pk),
        .i_overtemp_latch          (hot),
        .i_thermistor_underrange   (ur),
        .i_battery_sense_low       (bl),
        .i_battery_sense_recovered (br),
        .i_supply_low              (sl),
        .o_source_switch_drive     (sw),
        .o_regulator_on            (reg_on),
        .o_current_setting         (cur),
        .o_voltage_setting         (volt),
        .o_input_limit             (inp)
    );
    smbus_host_model host (
        .i_clk (clk),
        .i_sda (sda),
        .o_scl (scl),
        .o_sda (m_sda)
    );
    task chk(input [15:0] got, input [15:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task conclude;
        begin
            $display("checks %0d errors %0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task wrc(input [7:0] c, input [15:0] d);
        begin
            host.wr(`SLAVE_ADDR, c, d, n);
            chk({15'h0000, n}, 16'h0000);
        end
    endtask
    // Masked read keeps status checks to the bits under test.
    task rdc(input [7:0] c, input [15:0] m, input [15:0] e);
        begin
            host.rd(c, q, n);
            chk({15'h0000, n}, 16'h0000);
            chk(q & m, e);
        end
    endtask
    // ************************************************************
    // Test sequence.
    // ************************************************************
    initial begin
        host.w(2);
        rst_b = 1'b1;
        host.w(6);
        chk(cur, 16'h0080);
        chk(volt, 16'h4b00);
        rdc(`CMD_SPEC, 16'hffff, 16'h0002);
        rdc(`CMD_MAKER, 16'hffff, MAKER);
        rdc(`CMD_PART, 16'hffff, PART);
        rdc(`CMD_STATUS, 16'he000, 16'hc000);
        wrc(`CMD_CURRENT, 16'hffff);
        chk(cur, 16'h1f80);
        rdc(`CMD_STATUS, 16'h0040, 16'h0040);
        wrc(`CMD_CURRENT, 16'h0005);
        chk(cur, 16'h0080);
        wrc(`CMD_CURRENT, 16'h0fff);
        chk(cur, 16'h0f80);
        wrc(`CMD_VOLTAGE, 16'hffff);
        chk(volt, 16'h4b00);
        wrc(`CMD_VOLTAGE, 16'h03ff);
        chk(volt, 16'h0000);
        wrc(`CMD_VOLTAGE, 16'h300f);
        chk(volt, 16'h3000);
        wrc(`CMD_INPUT, 16'hffff);
        chk(inp, 16'h2afc);
        wrc(`CMD_INPUT, 16'h0fff);
        chk(inp, 16'h0f80);
        wrc(`CMD_SPEC, 16'h1234);
        chk(cur, 16'h0f80);
        host.wr(7'h0a, `CMD_CURRENT, 16'h0100, n);
        chk({15'h0000, n}, 16'h0001);
        chk(cur, 16'h0f80);
        wrc(`CMD_ALARM, 16'h0800);
        rdc(`CMD_STATUS, 16'h0800, 16'h0800);
        chk({15'h0000, reg_on}, 16'h0000);
        wrc(`CMD_CURRENT, 16'h1000);
        rdc(`CMD_STATUS, 16'h0800, 16'h0000);
        wrc(`CMD_MODE, 16'h0401);
        rdc(`CMD_STATUS, 16'h0001, 16'h0001);
        chk({15'h0000, reg_on}, 16'h0000);
        wrc(`CMD_MODE, 16'h0400);
        chk({15'h0000, reg_on}, 16'h0001);
        bl = 1'b1;
        br = 1'b0;
        host.w(8);
        chk(cur, 16'h0080);
        bl = 1'b0;
        br = 1'b1;
        host.w(8);
        chk(cur, 16'h1000);
        wrc(`CMD_MODE, 16'h0004);
        chk(volt, 16'h4b00);
        rdc(`CMD_STATUS, 16'h0010, 16'h0000);
        wrc(`CMD_CURRENT, 16'h1000);
        pk = 1'b0;
        host.w(10);
        chk(cur, 16'h0080);
        rdc(`CMD_STATUS, 16'h4010, 16'h0010);
        pk = 1'b1;
        lin = 1'b1;
        host.w(10);
        rdc(`CMD_STATUS, 16'h2000, 16'h2000);
        chk({15'h0000, sw}, 16'h0000);
        lin = 1'b0;
        ad = 1'b0;
        host.w(10);
        rdc(`CMD_STATUS, 16'h8000, 16'h0000);
        ad = 1'b1;
        wrc(`CMD_INPUT, 16'h0fff);
        hot = 1'b1;
        ur = 1'b1;
        host.w(10);
        rdc(`CMD_STATUS, 16'h0610, 16'h0610);
        chk({15'h0000, reg_on}, 16'h0000);
        hot = 1'b0;
        wrc(`CMD_MODE, 16'h0000);
        chk({15'h0000, reg_on}, 16'h0001);
        rdc(`CMD_STATUS, 16'h0410, 16'h0400);
        pk = 1'b0;
        host.w(10);
        rdc(`CMD_STATUS, 16'h0410, 16'h0010);
        pk = 1'b1;
        ur = 1'b0;
        sl = 1'b1;
        host.w(10);
        host.wr(`SLAVE_ADDR, `CMD_VOLTAGE, 16'h2000, n);
        chk({15'h0000, n}, 16'h0001);
        sl = 1'b0;
        host.w(10);
        chk(inp, 16'h0080);
        chk(volt, 16'h4b00);
        conclude;
    end
    // About 15k clocks of traffic are expected; allow over three times that.
    initial begin
        #400000;
        error_cnt = error_cnt + 1;
        conclude;
    end
endmodule
